/* File: logic/urx_rx_cfg.svh */
// Constants for the serial receiver with bit recovery and address filtering
`ifndef URX_RX_CFG_SVH
`define URX_RX_CFG_SVH

// Register offsets on the plain register port
`define URX_ADDR_STATUS 2'h0
`define URX_ADDR_DATA 2'h1
`define URX_ADDR_CTRL 2'h2

// Status register bit positions
`define URX_ST_RXC 7
`define URX_ST_TXC 6
`define URX_ST_FE 4
`define URX_ST_DBL 1
`define URX_ST_FILT 0

// Control register fields
`define URX_CT_NINTH 4
`define URX_CT_CSZ_HI 2

// Reset values
`define URX_CSZ_RST 3'h3
`define URX_DBL_RST 1'b0
`define URX_FILT_RST 1'b0

// Character size codes
`define URX_CSZ_9BIT 3'h7

// Sampling counts per bit and first voting state
`define URX_SPB_NORMAL 5'h10
`define URX_SPB_DOUBLE 5'h08
`define URX_FIRST_NORMAL 5'h08
`define URX_FIRST_DOUBLE 5'h04

`endif

/* File: logic/urx_pkg.sv */
// Types shared by the serial receiver modules
package urx_pkg;

  // Receive sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_STOP
  } urx_state_e;

  // Whole state of the receiver top
  typedef struct packed {
    urx_state_e st;
    logic [4:0] cnt;
    logic [3:0] bit_idx;
    logic [8:0] shreg;
    logic [8:0] rx_data;
    logic rx_fe;
    logic rxc;
    logic transmit_complete_flag;
    logic filt_en;
    logic dbl;
    logic [2:0] csz;
    logic [7:0] rdata;
    logic push;
  } urx_top_s;

  // Two-stage synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
  } urx_sync_s;

  // Running count of high voting samples
  typedef struct packed {
    logic [1:0] highs;
  } urx_vote_s;

endpackage : urx_pkg

/* File: logic/urx_sync.sv */
// Two flip-flop synchroniser for the serial input pin
`timescale 1ns/1ps
module urx_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Asynchronous input and its synchronised copy
  input wire logic d,
  output logic q
);

  urx_pkg::urx_sync_s s_q;
  urx_pkg::urx_sync_s s_d;

  // Next state: first stage feeds only the second
  always_comb begin
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
  end

  // Registers idle high so a line at rest reads as mark
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.s2;

endmodule : urx_sync

/* File: logic/urx_vote.sv */
// Three-sample majority voter for one received bit
`timescale 1ns/1ps
module urx_vote (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Sample controls
  input wire logic clr,
  input wire logic smp_en,
  input wire logic smp_last,
  input wire logic rx,
  // Voted level, valid in the cycle of the last sample
  output logic maj
);

  urx_pkg::urx_vote_s s_q;
  urx_pkg::urx_vote_s s_d;
  logic [1:0] total;

  // Earlier highs plus the sample now on the line
  assign total = s_q.highs + {1'b0, rx};
  // Two or three highs give one, otherwise zero
  assign maj = total[1];

  // Count highs; last sample consumes the vote
  always_comb begin
    s_d = s_q;
    if (clr || smp_last) begin
      s_d.highs = 2'h0;
    end else if (smp_en) begin
      s_d.highs = total;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : urx_vote

/* File: logic/urx_top.sv */
// Serial receiver: oversampled bit recovery, frame error check and address filter
`include "urx_rx_cfg.svh"
`timescale 1ns/1ps
module urx_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Serial line and oversampling tick
  input wire logic rxd,
  input wire logic sample_tick,
  // Transmitter event that sets the transmit complete flag
  input wire logic tx_done,
  // Register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // Shared settings toward the transmitter
  output logic [2:0] character_size_select,
  output logic double_speed_select,
  // Pulse when a frame enters the receive holding register
  output logic rx_push
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisation
  ////////////////////////////////////////////////////////////////////////////

  // Reset release pipeline
  logic [1:0] rst_pipe_q;
  // Synchronised reset used by everything else
  logic rst_sync_b;
  // Synchronised serial line
  logic rx_s;

  // Assert at once, release after two edges
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end

  assign rst_sync_b = rst_pipe_q[1];

  // Pin passes two flip-flops before any logic
  urx_sync u_rx_sync (
    .clk(sys_clk),
    .rst_b(rst_sync_b),
    .d(rxd),
    .q(rx_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sampling geometry
  ////////////////////////////////////////////////////////////////////////////

  urx_pkg::urx_top_s s_q;
  urx_pkg::urx_top_s s_d;

  // States per bit
  logic [4:0] spb;
  // First and last voting state
  logic [4:0] first;
  logic [4:0] last;
  // Data bits per frame for the current size code
  logic [3:0] nbits;
  // Voting strobes
  logic busy;
  logic smp_en;
  logic vlast;
  // Voted bit
  logic maj;
  // Frame type indicator and keep decision
  logic ftype;
  logic keep;
  // Data aligned to bit 0
  logic [8:0] aligned;

  // Divider and voting window follow the speed select
  always_comb begin
    if (s_q.dbl) begin
      spb = `URX_SPB_DOUBLE;
      first = `URX_FIRST_DOUBLE;
    end else begin
      spb = `URX_SPB_NORMAL;
      first = `URX_FIRST_NORMAL;
    end
    last = first + 5'h02;
  end

  // Size code to bit count, one code for both directions
  always_comb begin
    case (s_q.csz)
      3'h0: nbits = 4'h5;
      3'h1: nbits = 4'h6;
      3'h2: nbits = 4'h7;
      `URX_CSZ_9BIT: nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
  end

  // Vote strobes inside a frame
  assign busy = (s_q.st != urx_pkg::ST_IDLE);
  assign smp_en = sample_tick && busy && (s_q.cnt >= first) && (s_q.cnt <= last);
  assign vlast = sample_tick && busy && (s_q.cnt == last);

  // Majority voter
  urx_vote u_vote (
    .clk(sys_clk),
    .rst_b(rst_sync_b),
    .clr(!busy),
    .smp_en(smp_en),
    .smp_last(vlast),
    .rx(rx_s),
    .maj(maj)
  );

  // Ninth bit or first stop bit tells address from data
  assign ftype = (nbits == 4'h9) ? s_q.shreg[8] : maj;
  // Only address frames pass while filtering
  assign keep = !s_q.filt_en || ftype;
  // Unused upper bits come out as zero
  assign aligned = s_q.shreg >> (4'h9 - nbits);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_d = s_q;
    s_d.push = 1'b0;
    s_d.rdata = 8'h00;
    // Receive sequencer
    case (s_q.st)
      urx_pkg::ST_IDLE: begin
        // Counter rests on state 1, the number of the first low sample
        s_d.cnt = 5'h01;
        if (sample_tick && !rx_s) begin
          s_d.st = urx_pkg::ST_START;
          // The counter always holds the state of the sample now taken
          s_d.cnt = 5'h02;
        end
      end
      urx_pkg::ST_START: begin
        if (sample_tick) begin
          if (vlast && maj) begin
            // Mostly high: noise spike, look again
            s_d.st = urx_pkg::ST_IDLE;
            s_d.cnt = 5'h01;
          end else if (s_q.cnt == spb) begin
            s_d.st = urx_pkg::ST_DATA;
            s_d.cnt = 5'h01;
            s_d.bit_idx = 4'h0;
          end else begin
            s_d.cnt = s_q.cnt + 5'h01;
          end
        end
      end
      urx_pkg::ST_DATA: begin
        if (sample_tick) begin
          // Shift in LSB first at the last vote
          if (vlast) begin
            s_d.shreg = {maj, s_q.shreg[8:1]};
            s_d.bit_idx = s_q.bit_idx + 4'h1;
          end
          if (s_q.cnt == spb) begin
            s_d.cnt = 5'h01;
            if (s_q.bit_idx == nbits) begin
              s_d.st = urx_pkg::ST_STOP;
            end
          end else begin
            s_d.cnt = s_q.cnt + 5'h01;
          end
        end
      end
      urx_pkg::ST_STOP: begin
        if (vlast) begin
          // Frame ends at the first stop bit's last vote
          s_d.st = urx_pkg::ST_IDLE;
          s_d.cnt = 5'h01;
          if (keep) begin
            s_d.rx_data = aligned;
            s_d.rx_fe = !maj;
            s_d.rxc = 1'b1;
            s_d.push = 1'b1;
          end
        end else if (sample_tick) begin
          s_d.cnt = s_q.cnt + 5'h01;
        end
      end
      default: begin
        s_d.st = urx_pkg::ST_IDLE;
      end
    endcase

    // Transmit complete: set wins over write-one clear
    if (wr_en && (addr == `URX_ADDR_STATUS) && wdata[`URX_ST_TXC]) begin
      s_d.transmit_complete_flag = 1'b0;
    end
    if (tx_done) begin
      s_d.transmit_complete_flag = 1'b1;
    end

    // Register writes
    if (wr_en) begin
      if (addr == `URX_ADDR_STATUS) begin
        s_d.dbl = wdata[`URX_ST_DBL];
        s_d.filt_en = wdata[`URX_ST_FILT];
      end else if (addr == `URX_ADDR_CTRL) begin
        s_d.csz = wdata[`URX_CT_CSZ_HI:0];
      end
    end

    // Register reads, data one cycle later
    if (rd_en) begin
      if (addr == `URX_ADDR_STATUS) begin
        s_d.rdata = {s_q.rxc, s_q.transmit_complete_flag, 1'b0, s_q.rx_fe, 2'b00, s_q.dbl, s_q.filt_en};
      end else if (addr == `URX_ADDR_DATA) begin
        s_d.rdata = s_q.rx_data[7:0];
        // Reading empties the holder unless a frame lands now
        if (!s_d.push) begin
          s_d.rxc = 1'b0;
        end
      end else if (addr == `URX_ADDR_CTRL) begin
        s_d.rdata = {3'b000, s_q.rx_data[8], 1'b0, s_q.csz};
      end else begin
        // Unmapped reads return zero
        s_d.rdata = 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_q.st <= urx_pkg::ST_IDLE;
      s_q.cnt <= 5'h01;
      s_q.bit_idx <= 4'h0;
      s_q.shreg <= 9'h000;
      s_q.rx_data <= 9'h000;
      s_q.rx_fe <= 1'b0;
      s_q.rxc <= 1'b0;
      s_q.transmit_complete_flag <= 1'b0;
      s_q.filt_en <= `URX_FILT_RST;
      s_q.dbl <= `URX_DBL_RST;
      s_q.csz <= `URX_CSZ_RST;
      s_q.rdata <= 8'h00;
      s_q.push <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops; filter enable never leaves toward the transmitter
  assign rdata = s_q.rdata;
  assign character_size_select = s_q.csz;
  assign double_speed_select = s_q.dbl;
  assign rx_push = s_q.push;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_sync_b);

  // Stop vote that ends a frame
  sequence stop_vote_s;
    (s_q.st == urx_pkg::ST_STOP) && vlast;
  endsequence

  // Start vote that finds a spike
  sequence spike_s;
    (s_q.st == urx_pkg::ST_START) && vlast && maj;
  endsequence

  a_cnt_bound: assert property (busy |-> (s_q.cnt >= 5'h01) && (s_q.cnt <= spb))
    else $error("State counter left its per-bit range");

  a_cnt_wrap: assert property ((s_q.st == urx_pkg::ST_DATA) && sample_tick && (s_q.cnt == spb)
    |=> (s_q.cnt == 5'h01))
    else $error("State counter did not wrap at end of bit");

  a_vote_window: assert property (smp_en |-> (s_q.cnt - first) <= 5'h02)
    else $error("Vote sample taken outside centre states");

  a_start_align: assert property ((s_q.st == urx_pkg::ST_IDLE) && sample_tick && !rx_s
    |=> (s_q.st == urx_pkg::ST_START) && (s_q.cnt == 5'h02))
    else $error("Start edge did not realign counter");

  a_spike_reject: assert property (spike_s |=> (s_q.st == urx_pkg::ST_IDLE))
    else $error("Noise spike not rejected");

  a_early_rearm: assert property (stop_vote_s |=> (s_q.st == urx_pkg::ST_IDLE) && (s_q.cnt == 5'h01))
    else $error("Receiver not rearmed after stop vote");

  a_fe_stored: assert property (stop_vote_s ##0 keep |=> s_q.push && (s_q.rx_fe == !$past(maj)))
    else $error("Frame error not stored with frame");

  a_filter_drop: assert property (stop_vote_s ##0 (s_q.filt_en && !ftype) |=> !s_q.push)
    else $error("Data frame passed the address filter");

  a_addr_store: assert property (stop_vote_s ##0 ftype |=> s_q.push ##0 s_q.rxc)
    else $error("Address frame not stored");

  a_stop_entry: assert property ($rose(s_q.st == urx_pkg::ST_STOP) |-> $past(s_q.bit_idx) == nbits)
    else $error("Stop bit entered after wrong bit count");

  a_push_pulse: assert property (s_q.push |=> !s_q.push)
    else $error("Frame push longer than one cycle");

  // Counter parks on state 1 between frames
  a_idle_park: assert property (!busy |-> (s_q.cnt == 5'h01))
    else $error("State counter not parked while idle");

  // Ninth bit of a kept nine-bit frame reaches the holder
  a_ninth_store: assert property (stop_vote_s ##0 keep ##0 (nbits == 4'h9)
    |=> (s_q.rx_data[8] == $past(s_q.shreg[8])))
    else $error("Ninth bit not stored with frame");

  // Filter changes leave the shared size untouched
  a_filter_tx: assert property ($changed(s_q.filt_en) |-> $stable(s_q.csz))
    else $error("Filter change disturbed transmitter settings");

  // Holder stays full until its data is read
  a_rxc_hold: assert property (s_q.rxc && !(rd_en && (addr == `URX_ADDR_DATA)) |=> s_q.rxc)
    else $error("Receive complete flag lost without a read");

  // Read data stand for one cycle only
  a_rdata_idle: assert property (!$past(rd_en) |-> (s_q.rdata == 8'h00))
    else $error("Read data outside the read answer cycle");

  // Transmit complete set wins over a clearing write
  a_txc_set: assert property (tx_done |=> s_q.transmit_complete_flag)
    else $error("Transmit complete flag not set");

endmodule : urx_top

/* File: verification/urx_tx_model.sv */
// Remote serial transmitter model driving the receive line tick by tick
`timescale 1ns/1ps
module urx_tx_model (
  // Clock and oversampling tick
  input wire logic sys_clk,
  input wire logic sample_tick,
  // Serial line toward the receiver, idle high
  output logic rxd
);
  // Line rests high between frames
  initial rxd = 1'b1;
  // Count of tick waits that ran out
  int dead_ticks = 0;

  // Wait for the next oversampling tick; bounded so a dead tick cannot hang
  task automatic tick_wait();
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (sample_tick !== 1'b1 && i < 64);
    // A missing tick is reported by the bench as a mismatch
    if (sample_tick !== 1'b1) begin
      dead_ticks++;
    end
  endtask : tick_wait

  // One frame: start, data LSB first, first stop held stop_len samples, then high
  task automatic send(input logic [8:0] d, input int nbits, input int spb, input logic stop1,
                      input int stop_len, input int gbit, input logic [15:0] gmask);
    logic lvl;
    tick_wait();
    for (int b = 0; b <= nbits + 1; b++) begin
      // Bit rate locked to the receiver ticks, ninth bit and stop carry the type
      lvl = (b == 0) ? 1'b0 : (b > nbits) ? stop1 : d[b-1];
      for (int k = 0; k < ((b > nbits) ? stop_len : spb); k++) begin
        // Glitch mask inverts chosen samples of one bit
        rxd <= lvl ^ (b == gbit && gmask[k]);
        tick_wait();
      end
    end
    // Line back high: second stop bit or idle
    rxd <= 1'b1;
  endtask : send

  // Low pulse of n samples, too short to pass start validation
  task automatic noise(input int n);
    tick_wait();
    repeat (n) begin
      rxd <= 1'b0;
      tick_wait();
    end
    rxd <= 1'b1;
  endtask : noise
endmodule : urx_tx_model

/* File: verification/uart_rx_recovery_addr_filter_tb.sv */
// Self-checking bench: receiver against a behavioural model
`timescale 1ns/1ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("BAD %s exp %0h got %0h", nm, e, a); end end
module uart_rx_recovery_addr_filter_tb;
  // Design inputs
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sample_tick = 1'b0;
  logic tx_done = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  // Line and design outputs
  logic rxd;
  logic [7:0] rdata;
  logic [2:0] csz_out;
  logic dbl_out;
  logic rx_push;
  // Counters and model state
  int failures = 0;
  int num_checks = 0;
  int seed = 25903;
  int pushes = 0;
  int exp_pushes = 0;
  int tick_div = 0;
  int csz = 3;
  int dbl = 0;
  int filt = 0;
  int codes[5] = '{0, 1, 2, 3, 7};
  logic [8:0] exp_d = 9'h000;
  logic exp_fe = 1'b0;
  logic rxc_e = 1'b0;
  // Expected frames in order, frame error above the data
  logic [9:0] exp_q[$];
  logic [9:0] exp_f;

  // Clock and one-in-four oversampling tick
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tick_div <= (tick_div + 1) % 4;
    sample_tick <= (tick_div == 3);
  end
  // Count stored frames and hold each against the oldest expected one
  always @(posedge sys_clk) begin
    if (rx_push === 1'b1) begin
      pushes <= pushes + 1;
      if (exp_q.size() > 0) begin
        exp_f = exp_q.pop_front();
        `CHK("push_frame", exp_f, {u_urx_top.s_q.rx_fe, u_urx_top.s_q.rx_data})
      end
    end
  end

  urx_top u_urx_top (.sys_clk(sys_clk), .rst_b(rst_b), .rxd(rxd), .sample_tick(sample_tick),
    .tx_done(tx_done), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .character_size_select(csz_out), .double_speed_select(dbl_out), .rx_push(rx_push));
  urx_tx_model m_tx (.sys_clk(sys_clk), .sample_tick(sample_tick), .rxd(rxd));

  ////////////////////////////////////////////////////////////////////////////
  // One register write cycle
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  // One register read cycle; data taken in the following cycle
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // Status write with model settings, optional transmit complete clear
  task automatic wst(input logic clr_txc);
    wr(2'h0, {1'b0, clr_txc, 4'h0, 1'(dbl), 1'(filt)});
  endtask : wst

  // Send one frame, update the model, and optionally compare the stored result
  task automatic frame(input logic stop1, input logic ninth, input int slen, input logic [15:0] gm,
                       input logic chk);
    int nb;
    int first;
    int gb;
    logic [8:0] d;
    logic [8:0] e;
    logic typ;
    logic [7:0] st;
    nb = (csz < 4) ? csz + 5 : (csz == 7) ? 9 : 8;
    first = dbl ? 4 : 8;
    d = 9'($random(seed)) & ((9'h1 << nb) - 9'h1);
    if (nb == 9) d[8] = ninth;
    gb = 1 + ($unsigned($random(seed)) % nb);
    e = d;
    // Bit flips only if two of the three centre samples are disturbed
    if ($countones(gm[first-1 +: 3]) >= 2) e[gb-1] = ~e[gb-1];
    typ = (nb == 9) ? e[8] : stop1;
    // Model first: the push comes before the line returns to idle
    if (filt == 0 || typ) begin
      exp_pushes++;
      exp_d = e;
      exp_fe = ~stop1;
      rxc_e = 1'b1;
      exp_q.push_back({~stop1, e});
    end
    m_tx.send(d, nb, dbl ? 8 : 16, stop1, slen, gb, gm);
    if (chk) begin
      repeat (16) m_tx.tick_wait();
      `CHK("pushes", exp_pushes, pushes)
      rd(2'h0, st);
      `CHK("rxc", rxc_e, st[7])
      if (rxc_e) `CHK("fe", exp_fe, st[4])
      rd(2'h1, st);
      `CHK("data", exp_d[7:0], st)
      rd(2'h2, st);
      if (nb == 9) `CHK("ninth", exp_d[8], st[4])
      `CHK("size_reg", 3'(csz), st[2:0])
      rxc_e = 1'b0;
    end
  endtask : frame

  // Counts, verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog cuts a hang short
  initial begin
    #900000;
    failures++;
    $display("BAD watchdog exp 0 got 1");
    close_out();
  end

  // Main sequence
  initial begin
    logic [7:0] st;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK("size_rst", 3'h3, csz_out)
    `CHK("dbl_rst", 1'b0, dbl_out)
    rd(2'h3, st);
    `CHK("unmapped", 8'h00, st)
    // Transmit flag survives filter toggling, then clears on a written one
    @(posedge sys_clk);
    tx_done <= 1'b1;
    @(posedge sys_clk);
    tx_done <= 1'b0;
    filt = 1;
    wst(1'b0);
    rd(2'h0, st);
    `CHK("txc_keep", 1'b1, st[6])
    `CHK("size_keep", 3'h3, csz_out)
    filt = 0;
    wst(1'b1);
    rd(2'h0, st);
    `CHK("txc_clr", 1'b0, st[6])
    $display("test flags done");
    // Size codes 0, 1, 2, 3 and 7 at both speeds, glitched votes, stop errors, early restart, noise
    for (int s = 0; s < 2; s++) begin
      dbl = s;
      wst(1'b0);
      `CHK("dbl", 1'(dbl), dbl_out)
      foreach (codes[i]) begin
        csz = codes[i];
        wr(2'h2, 8'(csz));
        `CHK("size", 3'(csz), csz_out)
        frame(1'b1, 1'b0, dbl ? 8 : 16, 16'($random(seed)), 1'b1);
        frame(1'b0, 1'b1, dbl ? 8 : 16, 16'h0000, 1'b1);
      end
      frame(1'b1, 1'b1, dbl ? 5 : 9, 16'h0000, 1'b0);
      frame(1'b1, 1'b0, dbl ? 8 : 16, 16'h0000, 1'b1);
      m_tx.noise(dbl ? 4 : 8);
      repeat (16) m_tx.tick_wait();
      `CHK("noise", exp_pushes, pushes)
      $display("test speed %0d done", s);
    end
    // Address filter with eight-bit frames and with nine-bit frames
    dbl = 0;
    filt = 1;
    wst(1'b0);
    for (int i = 3; i < 8; i += 4) begin
      csz = i;
      wr(2'h2, 8'(csz));
      frame(1'b0, 1'b0, 16, 16'h0000, 1'b1);
      frame(1'b1, 1'b1, 16, 16'h0000, 1'b1);
      // Addressed slave opens the filter for its data, then closes it
      filt = 0;
      wst(1'b0);
      frame(1'(i == 7), 1'b0, 16, 16'h0000, 1'b1);
      filt = 1;
      wst(1'b0);
      frame(1'b0, 1'b1, 16, 16'h0000, 1'b1);
    end
    `CHK("tick_dead", 0, m_tx.dead_ticks)
    $display("test filter done");
    close_out();
  end
endmodule : uart_rx_recovery_addr_filter_tb
